// >>> design/duc_dac_ctrl.sv
// DAC double-rank update and built-in test control
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module duc_dac_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [10:0] board_addr_sw,
  input wire logic [3:0] immediate_sel,
  input wire logic trigger_enable_sel,
  input wire logic external_update_strobe_n,
  input wire logic end_of_conversion,
  output logic [191:0] dac_code,
  output logic field_connect,
  output logic test_bus1_en,
  output logic test_bus2_en,
  output logic ground_sense_return,
  output logic [3:0] test_mux_sel,
  output logic fail_led
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int PIN_W = 18;
  localparam logic [PIN_W-1:0] PIN_IDLE = 18'h00002;

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic eoc_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      eoc_q <= 1'b0;
    end else begin
      pin_meta <= {board_addr_sw, immediate_sel, trigger_enable_sel,
                   external_update_strobe_n, end_of_conversion};
      pin_sync <= pin_meta;
      eoc_q <= pin_sync[0];
    end
  end

  logic [10:0] sw_s;
  logic [3:0] imm_s;
  logic trig_en_s;
  logic strobe_n_s;
  logic eoc_s;

  assign sw_s = pin_sync[17:7];
  assign imm_s = pin_sync[6:3];
  assign trig_en_s = pin_sync[2];
  assign strobe_n_s = pin_sync[1];
  assign eoc_s = pin_sync[0];

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic hit;
  logic chan_wr;
  logic ctl_wr;
  logic [3:0] chan;
  logic program_update;
  logic eoc_rise;

  assign hit = addr[15:duc_pkg::BOARD_LSB] == sw_s;
  assign chan = addr[duc_pkg::CHAN_LSB +: duc_pkg::CHAN_W];
  assign chan_wr = wr && hit && !wdata[duc_pkg::DEST_BIT];
  assign ctl_wr = wr && hit && wdata[duc_pkg::DEST_BIT];
  assign program_update = ctl_wr && wdata[duc_pkg::CTRL_LSB + duc_pkg::CTL_UPDATE];
  assign eoc_rise = eoc_s && !eoc_q;

  // ----------------------------------------
  // External trigger width filter
  // ----------------------------------------
  localparam logic [5:0] TRIG_FIRE_CNT = 6'(duc_pkg::TRIG_LOW_CYCLES - 1);

  logic [5:0] trig_cnt;
  logic [5:0] next_trig_cnt;
  logic trig_fire;

  // Fires once per low pulse; a glitch shorter than the minimum never reaches the firing count
  assign trig_fire = trig_en_s && !strobe_n_s && trig_cnt == TRIG_FIRE_CNT;

  always_comb begin
    next_trig_cnt = trig_cnt;
    if (strobe_n_s || !trig_en_s) begin
      next_trig_cnt = 6'h00;
    end else if (trig_cnt != 6'h3F && trig_cnt <= TRIG_FIRE_CNT) begin
      next_trig_cnt = trig_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trig_cnt <= 6'h00;
    end else begin
      trig_cnt <= next_trig_cnt;
    end
  end

  logic delayed_update;

  assign delayed_update = program_update || trig_fire;

  // ----------------------------------------
  // Channel latch ranks
  // ----------------------------------------
  logic [11:0] rank1 [16];
  logic [11:0] rank2 [16];
  logic [11:0] next_rank1 [16];
  logic [11:0] next_rank2 [16];

  genvar i;
  generate
    for (i = 0; i < duc_pkg::CHANNELS; i++) begin : g_chan
      logic sel;
      logic immediate;

      assign sel = chan_wr && chan == 4'(i);
      assign immediate = imm_s[i / 4];

      always_comb begin
        next_rank1[i] = rank1[i];
        next_rank2[i] = rank2[i];
        if (sel) begin
          next_rank1[i] = wdata[duc_pkg::CODE_LSB +: duc_pkg::CODE_W];
        end
        if (immediate && sel) begin
          next_rank2[i] = wdata[duc_pkg::CODE_LSB +: duc_pkg::CODE_W];
        end else if (!immediate && delayed_update) begin
          next_rank2[i] = rank1[i];
        end
      end

      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          rank1[i] <= 12'h000;
          rank2[i] <= 12'h000;
        end else begin
          rank1[i] <= next_rank1[i];
          rank2[i] <= next_rank2[i];
        end
      end

      // Offset binary: code drives the converter untouched
      assign dac_code[i * 12 +: 12] = rank2[i];
    end
  endgenerate

  // ----------------------------------------
  // Control word and test routing
  // ----------------------------------------
  logic [6:0] ctrl;
  logic [6:0] next_ctrl;
  logic bus_active;
  logic next_bus_active;
  logic [3:0] next_mux_sel;
  logic [15:0] status;
  logic [15:0] next_rdata;

  always_comb begin
    next_ctrl = ctrl;
    next_mux_sel = test_mux_sel;
    next_bus_active = bus_active;
    if (ctl_wr) begin
      next_ctrl = wdata[duc_pkg::CTRL_LSB +: duc_pkg::CTRL_W];
      // Update is an action, not a setting
      next_ctrl[duc_pkg::CTL_UPDATE] = 1'b0;
    end
    if (chan_wr) begin
      next_mux_sel = chan;
    end
    // A channel write with CTL_TEST_EN set in the same cycle as end of conversion wins
    if (eoc_rise) begin
      next_bus_active = 1'b0;
    end
    if (chan_wr && ctrl[duc_pkg::CTL_TEST_EN]) begin
      next_bus_active = 1'b1;
    end
  end

  always_comb begin
    status = 16'h0000;
    status[duc_pkg::CTRL_LSB +: duc_pkg::CTRL_W] = ctrl;
    status[duc_pkg::ST_TADDR_LSB +: duc_pkg::CHAN_W] = test_mux_sel;
    status[duc_pkg::ST_TRIG_EN] = trig_en_s;
    status[duc_pkg::ST_BUS_ACTIVE] = bus_active;
    next_rdata = (rd && hit) ? status : 16'h0000;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= duc_pkg::CTRL_RESET;
      bus_active <= 1'b0;
      test_mux_sel <= 4'h0;
      rdata <= 16'h0000;
      field_connect <= 1'b1;
      test_bus1_en <= 1'b0;
      test_bus2_en <= 1'b0;
      ground_sense_return <= 1'b0;
      fail_led <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      bus_active <= next_bus_active;
      test_mux_sel <= next_mux_sel;
      rdata <= next_rdata;
      field_connect <= !next_ctrl[duc_pkg::CTL_ISOLATE];
      test_bus1_en <= next_bus_active && !next_ctrl[duc_pkg::CTL_BUS_SEL];
      test_bus2_en <= next_bus_active && next_ctrl[duc_pkg::CTL_BUS_SEL];
      ground_sense_return <= next_bus_active && next_ctrl[duc_pkg::CTL_BUS_SEL];
      fail_led <= next_ctrl[duc_pkg::CTL_FAIL];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic [11:0] sel_rank2;
  logic [191:0] rank1_flat;

  assign sel_rank2 = rank2[chan];

  always_comb begin
    for (int k = 0; k < duc_pkg::CHANNELS; k++) begin
      rank1_flat[k * 12 +: 12] = rank1[k];
    end
  end

  sequence s_strobe_held;
    !strobe_n_s && !$past(strobe_n_s, 29);
  endsequence

  sequence s_eoc_edge;
    eoc_rise && !chan_wr;
  endsequence

  chan_load_a: assert property (chan_wr |=> rank1[$past(chan)] == $past(wdata[11:0]))
    else $error("channel first rank not loaded");

  imm_copy_a: assert property (chan_wr && imm_s[chan[3:2]] |=> rank2[$past(chan)] == $past(wdata[11:0]))
    else $error("immediate channel did not update");

  delayed_hold_a: assert property (chan_wr && !imm_s[chan[3:2]] && !delayed_update
                                   |=> rank2[$past(chan)] == $past(sel_rank2))
    else $error("delayed channel changed early");

  prog_update_a: assert property (program_update && !imm_s[3] |=> rank2[15] == $past(rank1[15]))
    else $error("program update missed channel 15");

  // With the trigger disabled only a write may move any output code
  trig_gate_a: assert property (!trig_en_s && !program_update && !chan_wr |=> $stable(dac_code))
    else $error("trigger acted while disabled");

  trig_width_a: assert property (trig_fire |-> s_strobe_held)
    else $error("trigger fired on short pulse");

  read_quiet_a: assert property (rd && !trig_fire |=> $stable(rank1_flat) && $stable(dac_code) && $stable(ctrl))
    else $error("read disturbed state");

  field_switch_a: assert property (ctl_wr |=> field_connect == !$past(wdata[9]))
    else $error("field switch not programmed");

  test_addr_a: assert property (chan_wr |=> test_mux_sel == $past(chan))
    else $error("test address not captured");

  bus_release_a: assert property (s_eoc_edge |=> !test_bus1_en && !test_bus2_en)
    else $error("test bus not released");

  gnd_sense_a: assert property (test_bus2_en == ground_sense_return)
    else $error("ground sense out of step");

  board_match_a: assert property (wr && !hit |=> $stable(ctrl) && $stable(rank1_flat))
    else $error("write acted at foreign address");

  status_read_a: assert property (rd && hit |=> rdata == $past(status))
    else $error("status read wrong");

endmodule : duc_dac_ctrl

`default_nettype wire

// >>> design/duc_pkg.sv
// Constants shared by the DAC update and test control block
package duc_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int CHANNELS = 16;
  localparam int CODE_W = 12;
  localparam int GROUPS = 4;
  localparam int CTRL_W = 7;
  localparam int BUS_W = 16;
  localparam int CHAN_W = 4;
  localparam int BOARD_W = 11;
  // ----------------------------------------
  // Bus word fields
  // ----------------------------------------
  localparam int DEST_BIT = 15;
  localparam int CODE_LSB = 0;
  localparam int CTRL_LSB = 8;
  localparam int CHAN_LSB = 1;
  localparam int BOARD_LSB = 5;
  // ----------------------------------------
  // Control word bits (above CTRL_LSB)
  // ----------------------------------------
  localparam int CTL_UPDATE = 0;
  localparam int CTL_ISOLATE = 1;
  localparam int CTL_TEST_EN = 2;
  localparam int CTL_BUS_SEL = 3;
  localparam int CTL_FAIL = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  // ----------------------------------------
  // Status word bits
  // ----------------------------------------
  localparam int ST_BUS_ACTIVE = 0;
  localparam int ST_TRIG_EN = 1;
  localparam int ST_TADDR_LSB = 4;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TRIG_LOW_NS = 150;
  localparam int TRIG_LOW_CYCLES = (TRIG_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRIG_CNT_W = 6;
endpackage : duc_pkg

// >>> test/duc_far_model.sv
// Far-side model: update trigger source and test-bus converter
`timescale 1ns/1ps
`default_nettype none

module duc_far_model #(
  parameter int EOC_DELAY = 24
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic test_bus1_en,
  input wire logic test_bus2_en,
  input wire logic trig_go,
  input wire logic [7:0] trig_len,
  output logic external_update_strobe_n,
  output logic end_of_conversion
);
  logic [7:0] trig_cnt;
  logic [7:0] conv_cnt;

  // Strobe idles high, held low for exactly the commanded count
  assign external_update_strobe_n = (trig_cnt == 8'h00);
  // Converter finishes a fixed time after a bus is driven; done held 4 cycles
  assign end_of_conversion = (conv_cnt >= 8'(EOC_DELAY));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trig_cnt <= 8'h00;
      conv_cnt <= 8'h00;
    end else begin
      if (trig_go) begin
        trig_cnt <= trig_len;
      end else if (trig_cnt != 8'h00) begin
        trig_cnt <= trig_cnt - 8'h01;
      end
      if (conv_cnt == 8'(EOC_DELAY + 3)) begin
        conv_cnt <= 8'h00;
      end else if (conv_cnt != 8'h00 || test_bus1_en || test_bus2_en) begin
        conv_cnt <= conv_cnt + 8'h01;
      end
    end
  end
endmodule : duc_far_model

`default_nettype wire

// >>> test/test_duc_dac_ctrl.sv
// Self-checking bench for the DAC update and test control block
`timescale 1ns/1ps
`default_nettype none

module test_duc_dac_ctrl;
  localparam logic [10:0] BASE = 11'h5A3;
  logic clk, resetn, wr, rd, trig_en, trig_go, eoc, strobe_n;
  logic [15:0] addr, wdata, rdata, rv;
  logic [3:0] imm_sel, mux_sel;
  logic [7:0] trig_len;
  logic [191:0] dac_code;
  logic field_connect, bus1, bus2, gsr, fail_led;
  logic [11:0] rank1 [16];
  logic [11:0] exp_code [16];
  int n_mismatch, cmp_count;

  duc_dac_ctrl u_duc_dac_ctrl (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .board_addr_sw(BASE), .immediate_sel(imm_sel), .trigger_enable_sel(trig_en),
    .external_update_strobe_n(strobe_n), .end_of_conversion(eoc), .dac_code(dac_code),
    .field_connect(field_connect), .test_bus1_en(bus1), .test_bus2_en(bus2), .ground_sense_return(gsr),
    .test_mux_sel(mux_sel), .fail_led(fail_led));
  duc_far_model u_duc_far_model (.clk(clk), .resetn(resetn), .test_bus1_en(bus1), .test_bus2_en(bus2),
    .trig_go(trig_go), .trig_len(trig_len), .external_update_strobe_n(strobe_n), .end_of_conversion(eoc));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------
  // Bus access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
    cmp_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask : chk

  task automatic chk_codes();
    for (int i = 0; i < 16; i++) begin
      chk({4'h0, dac_code[12*i +: 12]}, {4'h0, exp_code[i]}, "channel code");
    end
  endtask : chk_codes

  task automatic bus_wr(input logic [3:0] ch, input logic [15:0] d, input logic [10:0] base);
    @(posedge clk);
    addr <= {base, ch, 1'b0};
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] ch, input logic [10:0] base, output logic [15:0] d);
    @(posedge clk);
    addr <= {base, ch, 1'b0};
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd

  task automatic put_ch(input logic [3:0] ch, input logic [11:0] code);
    bus_wr(ch, {4'h0, code}, BASE);
    rank1[ch] = code;
    if (imm_sel[ch[3:2]]) begin
      exp_code[ch] = code;
    end
    chk(16'(mux_sel), 16'(ch), "test channel");
  endtask : put_ch

  task automatic apply_update();
    for (int i = 0; i < 16; i++) begin
      if (!imm_sel[i/4]) begin
        exp_code[i] = rank1[i];
      end
    end
  endtask : apply_update

  // Idle margin covers the two-stage sync plus the firing count
  task automatic pulse(input logic [7:0] len, input logic en);
    @(posedge clk);
    trig_en <= en;
    trig_len <= len;
    trig_go <= 1'b1;
    @(posedge clk);
    trig_go <= 1'b0;
    repeat (int'(len) + 45) @(posedge clk);
    #1;
  endtask : pulse

  task automatic wait_bus_off();
    int n;
    n = 0;
    while ((bus1 | bus2) !== 1'b0 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(bus1 | bus2), 16'h0000, "bus release");
  endtask : wait_bus_off

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    {wr, rd, trig_go, addr, wdata, trig_len} = '0;
    trig_en = 1'b1;
    imm_sel = 4'b0011;
    n_mismatch = 0;
    cmp_count = 0;
    for (int i = 0; i < 16; i++) begin
      rank1[i] = 12'h000;
      exp_code[i] = 12'h000;
    end
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(16'({fail_led, gsr, bus2, bus1, field_connect}), 16'h0001, "reset outputs");
    for (int i = 0; i < 16; i++) begin
      put_ch(4'(i), 12'h0F0 ^ (12'(i) * 12'h111));
    end
    chk_codes();
    bus_wr(4'h2, 16'h0ABC, BASE ^ 11'h001);
    chk_codes();
    bus_rd(4'h2, BASE ^ 11'h001, rv);
    chk(rv, 16'h0000, "foreign read");
    bus_rd(4'h9, BASE, rv);
    chk(rv, 16'h00F2, "status");
    chk_codes();
    bus_wr(4'h0, 16'h8100, BASE);
    apply_update();
    chk_codes();
    for (int i = 8; i < 16; i++) begin
      put_ch(4'(i), ~rank1[i]);
    end
    pulse(8'd20, 1'b1);
    chk_codes();
    pulse(8'd40, 1'b0);
    chk_codes();
    pulse(8'd32, 1'b1);
    apply_update();
    chk_codes();
    bus_wr(4'h0, 16'h9E00, BASE);
    chk(16'({fail_led, field_connect}), 16'h0002, "field and lamp");
    bus_rd(4'h0, BASE, rv);
    chk(rv, 16'h1EF2, "control readback");
    put_ch(4'h5, 12'h7FF);
    chk(16'({gsr, bus2, bus1}), 16'h0006, "bus 2 on");
    wait_bus_off();
    chk(16'({gsr, bus2, bus1}), 16'h0000, "bus 2 off");
    bus_wr(4'h0, 16'h9600, BASE);
    put_ch(4'hC, 12'h800);
    chk(16'({gsr, bus2, bus1}), 16'h0001, "bus 1 on");
    wait_bus_off();
    chk_codes();
    wrap_up();
  end

  // Sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
endmodule : test_duc_dac_ctrl

`default_nettype wire
